/* File: core/cmpt_acc_if.sv */
// Interface between the sequencer and the memory access port.
`timescale 1ns/10ps
`default_nettype none

interface cmpt_acc_if;
	logic                        go;    // One-cycle request to start an access.
	logic                        we;    // High for a write.
	logic [cmpt_pkg::ADDR_W-1:0] addr;  // Word address.
	logic [cmpt_pkg::DATA_W-1:0] wdata; // Write data.
	logic                        ready; // Port idle, a request may start.
	logic                        done;  // One-cycle pulse, access finished.
	logic [cmpt_pkg::DATA_W-1:0] rdata; // Read data, valid with done.

	modport seq  (output go, we, addr, wdata, input ready, done, rdata);
	modport port (input go, we, addr, wdata, output ready, done, rdata);
endinterface : cmpt_acc_if

`default_nettype wire

/* File: core/cmpt_core_memory_pattern_tester.sv */
// Top of the core memory pattern tester: test sequencer and reporting.
`timescale 1ns/10ps
`default_nettype none

module cmpt_core_memory_pattern_tester (
	// Clock, reset and clock enable.
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        clk_en_i,
	// Test control.
	input  wire logic                        run_i,
	input  wire logic [1:0]                  test_sel_i,
	input  wire logic [cmpt_pkg::ADDR_W-1:0] zone_lo_i,
	input  wire logic [cmpt_pkg::ADDR_W-1:0] zone_hi_i,
	// Status.
	output var  logic                        busy_o,
	output var  logic                        halted_o,
	output var  logic                        phase_o,
	output var  logic [1:0]                  test_o,
	output var  logic                        pass_done_o,
	// Error report.
	output var  logic                        err_o,
	output var  logic                        err_ones_o,
	output var  logic                        err_zeros_o,
	output var  logic [cmpt_pkg::ADDR_W-1:0] err_addr_o,
	output var  logic [cmpt_pkg::DATA_W-1:0] err_exp_o,
	output var  logic [cmpt_pkg::DATA_W-1:0] err_got_o,
	output var  logic [cmpt_pkg::CNT_W-1:0]  err_count_o,
	// Memory port.
	output var  logic                        mem_req_o,
	output var  logic                        mem_we_o,
	output var  logic [cmpt_pkg::ADDR_W-1:0] mem_addr_o,
	output var  logic [cmpt_pkg::DATA_W-1:0] mem_wdata_o,
	input  wire logic [cmpt_pkg::DATA_W-1:0] mem_rdata_i,
	input  wire logic                        mem_done_i
);

	// -------------------------------------------------------------------------
	// Sequencer state
	// -------------------------------------------------------------------------
	cmpt_pkg::cmpt_state_t       state_r, state_nxt;   // Sequencer state.
	logic [cmpt_pkg::ADDR_W-1:0] addr_r, addr_nxt;     // Scan address.
	logic [cmpt_pkg::ADDR_W-1:0] loc_r, loc_nxt;       // Unique test location pointer.
	logic [cmpt_pkg::ADDR_W-1:0] lo_r, lo_nxt;         // Zone bottom for this run.
	logic [cmpt_pkg::ADDR_W-1:0] hi_r, hi_nxt;         // Zone top for this run.
	logic [1:0]                  sel_r, sel_nxt;       // Selected test.
	logic [2:0]                  pat_r, pat_nxt;       // Pattern list index.
	logic                        phase_r, phase_nxt;   // Phase or noise part flag.
	logic                        pend_r, pend_nxt;     // An access is outstanding.
	logic                        pass_nxt;             // A full pass ends now.

	cmpt_acc_if acc ();                                // Access request carrier.

	// -------------------------------------------------------------------------
	// Access decode
	// -------------------------------------------------------------------------
	wire st_ad_wr  = (state_r == cmpt_pkg::ST_AD_WR);
	wire st_ad_rd  = (state_r == cmpt_pkg::ST_AD_RD);
	wire st_ua_fl  = (state_r == cmpt_pkg::ST_UA_FILL);
	wire st_ua_wr  = (state_r == cmpt_pkg::ST_UA_WR);
	wire st_ua_rd  = (state_r == cmpt_pkg::ST_UA_RD);
	wire st_ua_ck  = (state_r == cmpt_pkg::ST_UA_CHK);
	wire st_ua_rs  = (state_r == cmpt_pkg::ST_UA_RST);
	wire st_pt_wr  = (state_r == cmpt_pkg::ST_PT_WR);
	wire st_pt_rd  = (state_r == cmpt_pkg::ST_PT_RD);
	wire st_nz_ld  = (state_r == cmpt_pkg::ST_NZ_LOAD);
	wire st_nz_r1  = (state_r == cmpt_pkg::ST_NZ_R1);
	wire st_nz_c1  = (state_r == cmpt_pkg::ST_NZ_C1);
	wire st_nz_r2  = (state_r == cmpt_pkg::ST_NZ_R2);
	wire st_nz_c2  = (state_r == cmpt_pkg::ST_NZ_C2);

	// Background of the unique test: ones in phase zero, zeros after.
	wire [cmpt_pkg::DATA_W-1:0] bg = phase_r ? cmpt_pkg::ALL_ZEROS : cmpt_pkg::ALL_ONES;
	// Noise value loaded at the scan address for the current part.
	wire [cmpt_pkg::DATA_W-1:0] nv = cmpt_pkg::noise_value(addr_r, phase_r);
	// Current fixed pattern.
	wire [cmpt_pkg::DATA_W-1:0] pv = cmpt_pkg::pattern_of(pat_r);
	// Lowest address the address test may touch.
	wire [cmpt_pkg::ADDR_W-1:0] ad_lo = cmpt_pkg::floor_lo(lo_r);

	wire at_top  = (addr_r == hi_r);                   // Scan reached the zone top.
	wire at_loc  = (addr_r == loc_r);                  // Scan is on the test location.
	wire is_read = st_ad_rd | st_ua_rd | st_ua_ck | st_pt_rd | st_nz_r1 | st_nz_r2;
	wire is_wr   = st_ad_wr | st_ua_fl | st_ua_wr | st_ua_rs | st_pt_wr | st_nz_ld
	             | st_nz_c1 | st_nz_c2;
	wire use_loc = st_ua_wr | st_ua_rd | st_ua_rs;     // Access aims at the pointer.

	// Write data for each writing state.
	wire [cmpt_pkg::DATA_W-1:0] wdata =
		st_ad_wr            ? addr_r :
		(st_ua_fl|st_ua_rs) ? bg :
		st_ua_wr            ? ~bg :
		st_pt_wr            ? pv :
		st_nz_c1            ? ~nv :
		nv;

	// Expected data for each checking read.
	wire [cmpt_pkg::DATA_W-1:0] exp_data =
		st_ad_rd ? addr_r :
		st_ua_rd ? ~bg :
		st_ua_ck ? (at_loc ? ~bg : bg) :
		st_pt_rd ? pv :
		nv;
	// The second noise read is a stress read and is not compared.
	wire checks   = st_ad_rd | st_ua_rd | st_ua_ck | st_pt_rd | st_nz_r1;
	wire mismatch = acc.done & pend_r & checks & (acc.rdata != exp_data);

	// One access at a time: start only when idle and nothing outstanding.
	assign acc.go    = (is_read | is_wr) & acc.ready & ~pend_r & run_i;
	assign acc.we    = is_wr;
	assign acc.addr  = use_loc ? loc_r : addr_r;
	assign acc.wdata = wdata;

	wire step = acc.done & pend_r;                     // Current access finished.

	// -------------------------------------------------------------------------
	// Next-state logic
	// -------------------------------------------------------------------------
	// Every state that touches memory advances only on its own completion,
	// so a slow memory stretches the sequence but never reorders it.
	always_comb
	begin
		state_nxt = state_r;
		addr_nxt  = addr_r;
		loc_nxt   = loc_r;
		lo_nxt    = lo_r;
		hi_nxt    = hi_r;
		sel_nxt   = sel_r;
		pat_nxt   = pat_r;
		phase_nxt = phase_r;
		pass_nxt  = 1'b0;
		pend_nxt  = acc.go ? 1'b1 : (step ? 1'b0 : pend_r);
		if (!run_i)
		begin
			// Dropping run abandons the test; a stray completion is ignored.
			state_nxt = cmpt_pkg::ST_IDLE;
			pend_nxt  = 1'b0;
		end
		else
		begin
			case (state_r)
				cmpt_pkg::ST_IDLE:
				begin
					// Zone and test are sampled once at start.
					sel_nxt   = test_sel_i;
					lo_nxt    = zone_lo_i;
					hi_nxt    = zone_hi_i;
					pat_nxt   = cmpt_pkg::PAT_RST;
					phase_nxt = 1'b0;
					addr_nxt  = zone_lo_i;
					loc_nxt   = zone_lo_i;
					case (test_sel_i)
						cmpt_pkg::TEST_ADDR_DOWN:
						begin
							addr_nxt  = zone_hi_i;
							state_nxt = cmpt_pkg::ST_AD_WR;
						end
						cmpt_pkg::TEST_UNIQUE:  state_nxt = cmpt_pkg::ST_UA_FILL;
						cmpt_pkg::TEST_PATTERN: state_nxt = cmpt_pkg::ST_PT_WR;
						default:                state_nxt = cmpt_pkg::ST_NZ_LOAD;
					endcase
				end
				cmpt_pkg::ST_AD_WR:
					if (step)
					begin
						if (addr_r == ad_lo)
							state_nxt = cmpt_pkg::ST_AD_RD;
						else
							addr_nxt = addr_r - 16'h0001;
					end
				cmpt_pkg::ST_AD_RD:
					if (step)
					begin
						if (mismatch)
							state_nxt = cmpt_pkg::ST_HALT;
						else if (at_top)
						begin
							pass_nxt  = 1'b1;
							addr_nxt  = hi_r;
							state_nxt = cmpt_pkg::ST_AD_WR;
						end
						else
							addr_nxt = addr_r + 16'h0001;
					end
				cmpt_pkg::ST_UA_FILL:
					if (step)
					begin
						if (at_top)
							state_nxt = cmpt_pkg::ST_UA_WR;
						else
							addr_nxt = addr_r + 16'h0001;
					end
				cmpt_pkg::ST_UA_WR:
					if (step)
						state_nxt = cmpt_pkg::ST_UA_RD;
				cmpt_pkg::ST_UA_RD:
					if (step)
					begin
						addr_nxt  = lo_r;
						state_nxt = cmpt_pkg::ST_UA_CHK;
					end
				cmpt_pkg::ST_UA_CHK:
					if (step)
					begin
						if (at_top)
							state_nxt = cmpt_pkg::ST_UA_RST;
						else
							addr_nxt = addr_r + 16'h0001;
					end
				cmpt_pkg::ST_UA_RST:
					// Restoring the background keeps the next field check honest.
					if (step)
					begin
						if (loc_r == hi_r)
						begin
							loc_nxt   = lo_r;
							addr_nxt  = lo_r;
							phase_nxt = ~phase_r;
							pass_nxt  = phase_r;
							state_nxt = cmpt_pkg::ST_UA_FILL;
						end
						else
						begin
							loc_nxt   = loc_r + 16'h0001;
							state_nxt = cmpt_pkg::ST_UA_WR;
						end
					end
				cmpt_pkg::ST_PT_WR:
					if (step)
					begin
						if (at_top)
						begin
							addr_nxt  = lo_r;
							state_nxt = cmpt_pkg::ST_PT_RD;
						end
						else
							addr_nxt = addr_r + 16'h0001;
					end
				cmpt_pkg::ST_PT_RD:
					if (step)
					begin
						if (at_top)
						begin
							addr_nxt  = lo_r;
							pass_nxt  = (pat_r == cmpt_pkg::PAT_LAST);
							pat_nxt   = (pat_r == cmpt_pkg::PAT_LAST) ?
							            cmpt_pkg::PAT_RST : pat_r + 3'h1;
							state_nxt = cmpt_pkg::ST_PT_WR;
						end
						else
							addr_nxt = addr_r + 16'h0001;
					end
				cmpt_pkg::ST_NZ_LOAD:
					if (step)
					begin
						if (at_top)
						begin
							addr_nxt  = lo_r;
							state_nxt = cmpt_pkg::ST_NZ_R1;
						end
						else
							addr_nxt = addr_r + 16'h0001;
					end
				cmpt_pkg::ST_NZ_R1:
					if (step)
						state_nxt = cmpt_pkg::ST_NZ_C1;
				cmpt_pkg::ST_NZ_C1:
					if (step)
						state_nxt = cmpt_pkg::ST_NZ_R2;
				cmpt_pkg::ST_NZ_R2:
					if (step)
						state_nxt = cmpt_pkg::ST_NZ_C2;
				cmpt_pkg::ST_NZ_C2:
					if (step)
					begin
						if (at_top)
						begin
							addr_nxt  = lo_r;
							phase_nxt = ~phase_r;
							pass_nxt  = phase_r;
							state_nxt = cmpt_pkg::ST_NZ_LOAD;
						end
						else
						begin
							addr_nxt  = addr_r + 16'h0001;
							state_nxt = cmpt_pkg::ST_NZ_R1;
						end
					end
				cmpt_pkg::ST_HALT:
					state_nxt = cmpt_pkg::ST_HALT;
				default:
					state_nxt = cmpt_pkg::ST_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// State registers
	// -------------------------------------------------------------------------
	// Status outputs are registered from the next values so that they line up
	// with the state they describe.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_r     <= cmpt_pkg::ST_IDLE;
			addr_r      <= '0;
			loc_r       <= '0;
			lo_r        <= '0;
			hi_r        <= '0;
			sel_r       <= cmpt_pkg::TEST_ADDR_DOWN;
			pat_r       <= cmpt_pkg::PAT_RST;
			phase_r     <= 1'b0;
			pend_r      <= 1'b0;
			busy_o      <= 1'b0;
			halted_o    <= 1'b0;
			phase_o     <= 1'b0;
			test_o      <= cmpt_pkg::TEST_ADDR_DOWN;
			pass_done_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			state_r     <= state_nxt;
			addr_r      <= addr_nxt;
			loc_r       <= loc_nxt;
			lo_r        <= lo_nxt;
			hi_r        <= hi_nxt;
			sel_r       <= sel_nxt;
			pat_r       <= pat_nxt;
			phase_r     <= phase_nxt;
			pend_r      <= pend_nxt;
			busy_o      <= (state_nxt != cmpt_pkg::ST_IDLE);
			halted_o    <= (state_nxt == cmpt_pkg::ST_HALT);
			phase_o     <= phase_nxt;
			test_o      <= sel_nxt;
			pass_done_o <= pass_nxt;
		end
	end

	// -------------------------------------------------------------------------
	// Submodules
	// -------------------------------------------------------------------------
	cmpt_mem_port u_port (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.clk_en_i    (clk_en_i),
		.acc         (acc),
		.mem_req_o   (mem_req_o),
		.mem_we_o    (mem_we_o),
		.mem_addr_o  (mem_addr_o),
		.mem_wdata_o (mem_wdata_o),
		.mem_rdata_i (mem_rdata_i),
		.mem_done_i  (mem_done_i)
	);

	// The error count restarts each time a test is started from idle.
	cmpt_err_report u_err (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.clk_en_i    (clk_en_i),
		.clear_i     ((state_r == cmpt_pkg::ST_IDLE) & run_i),
		.err_i       (mismatch),
		.addr_i      (acc.addr),
		.exp_i       (exp_data),
		.got_i       (acc.rdata),
		.err_o       (err_o),
		.err_ones_o  (err_ones_o),
		.err_zeros_o (err_zeros_o),
		.err_addr_o  (err_addr_o),
		.err_exp_o   (err_exp_o),
		.err_got_o   (err_got_o),
		.err_count_o (err_count_o)
	);

endmodule : cmpt_core_memory_pattern_tester

`default_nettype wire

/* File: core/cmpt_err_report.sv */
// Error capture and classification for the core memory pattern tester.
`timescale 1ns/10ps
`default_nettype none

module cmpt_err_report (
	// Clock and reset.
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        clk_en_i,
	// Error event from the sequencer.
	input  wire logic                        clear_i,
	input  wire logic                        err_i,
	input  wire logic [cmpt_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [cmpt_pkg::DATA_W-1:0] exp_i,
	input  wire logic [cmpt_pkg::DATA_W-1:0] got_i,
	// Report.
	output var  logic                        err_o,
	output var  logic                        err_ones_o,
	output var  logic                        err_zeros_o,
	output var  logic [cmpt_pkg::ADDR_W-1:0] err_addr_o,
	output var  logic [cmpt_pkg::DATA_W-1:0] err_exp_o,
	output var  logic [cmpt_pkg::DATA_W-1:0] err_got_o,
	output var  logic [cmpt_pkg::CNT_W-1:0]  err_count_o
);
	wire from_ones  = err_i & (exp_i == cmpt_pkg::ALL_ONES);  // Disturbed minus-one.
	wire from_zeros = err_i & (exp_i == cmpt_pkg::ALL_ZEROS); // Disturbed zero.
	wire sat        = (err_count_o == cmpt_pkg::CNT_MAX);     // Counter is full.

	// An error in the clearing cycle still counts, so the set wins.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			err_o       <= 1'b0;
			err_ones_o  <= 1'b0;
			err_zeros_o <= 1'b0;
			err_addr_o  <= '0;
			err_exp_o   <= '0;
			err_got_o   <= '0;
			err_count_o <= '0;
		end
		else if (clk_en_i)
		begin
			err_o       <= err_i;
			err_ones_o  <= from_ones;
			err_zeros_o <= from_zeros;
			if (err_i)
			begin
				err_addr_o <= addr_i;
				err_exp_o  <= exp_i;
				err_got_o  <= got_i;
			end
			if (clear_i)
				err_count_o <= err_i ? 16'h0001 : 16'h0000;
			else if (err_i && !sat)
				err_count_o <= err_count_o + 16'h0001;
		end
	end
endmodule : cmpt_err_report

`default_nettype wire

/* File: core/cmpt_mem_port.sv */
// Single-outstanding memory access port with registered memory pins.
`timescale 1ns/10ps
`default_nettype none

module cmpt_mem_port (
	// Clock and reset.
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        clk_en_i,
	// Sequencer side.
	cmpt_acc_if.port                         acc,
	// Memory side.
	output var  logic                        mem_req_o,
	output var  logic                        mem_we_o,
	output var  logic [cmpt_pkg::ADDR_W-1:0] mem_addr_o,
	output var  logic [cmpt_pkg::DATA_W-1:0] mem_wdata_o,
	input  wire logic [cmpt_pkg::DATA_W-1:0] mem_rdata_i,
	input  wire logic                        mem_done_i
);
	logic                        done_r;  // Completion pulse.
	logic [cmpt_pkg::DATA_W-1:0] rdata_r; // Captured read word.

	// A new request is taken only while nothing is outstanding.
	assign acc.ready = ~mem_req_o;
	assign acc.done  = done_r;
	assign acc.rdata = rdata_r;

	// The request stands until the memory reports completion.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= '0;
			mem_wdata_o <= '0;
			done_r      <= 1'b0;
			rdata_r     <= '0;
		end
		else if (clk_en_i)
		begin
			done_r <= mem_req_o & mem_done_i;
			if (mem_req_o && mem_done_i)
			begin
				mem_req_o <= 1'b0;
				rdata_r   <= mem_rdata_i;
			end
			else if (!mem_req_o && acc.go)
			begin
				mem_req_o   <= 1'b1;
				mem_we_o    <= acc.we;
				mem_addr_o  <= acc.addr;
				mem_wdata_o <= acc.wdata;
			end
		end
	end
endmodule : cmpt_mem_port

`default_nettype wire

/* File: core/cmpt_pkg.sv */
// Shared constants, types and helpers for the core memory pattern tester.
`default_nettype none

package cmpt_pkg;

	// -------------------------------------------------------------------------
	// Widths and data constants
	// -------------------------------------------------------------------------
	localparam int unsigned ADDR_W = 16;            // Word address width.
	localparam int unsigned DATA_W = 16;            // Data word width, all bits exercised.
	localparam int unsigned CNT_W  = 16;            // Error counter width.
	localparam logic [DATA_W-1:0] ALL_ONES  = 16'hFFFF; // The minus-one word.
	localparam logic [DATA_W-1:0] ALL_ZEROS = 16'h0000; // The zero word.
	localparam logic [ADDR_W-1:0] TRAP_LIMIT = 16'h0040; // Lowest address the address test may use.
	localparam int unsigned NOISE_BIT_A = 3;         // First address bit of the noise split.
	localparam int unsigned NOISE_BIT_B = 9;         // Second address bit of the noise split.

	// -------------------------------------------------------------------------
	// Test selection codes
	// -------------------------------------------------------------------------
	localparam logic [1:0] TEST_ADDR_DOWN = 2'h0;    // Descending address-in-location.
	localparam logic [1:0] TEST_UNIQUE    = 2'h1;    // Unique address selection.
	localparam logic [1:0] TEST_PATTERN   = 2'h2;    // Fixed pattern list.
	localparam logic [1:0] TEST_NOISE     = 2'h3;    // Worst case noise.

	// -------------------------------------------------------------------------
	// Pattern list and reset values
	// -------------------------------------------------------------------------
	localparam logic [2:0] PAT_LAST = 3'h5;          // Index of the last pattern.
	localparam logic [2:0] PAT_RST  = 3'h0;          // Pattern index after reset.
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF; // Error counter saturates here.

	// Sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE, ST_AD_WR, ST_AD_RD, ST_UA_FILL, ST_UA_WR, ST_UA_RD, ST_UA_CHK,
		ST_UA_RST, ST_PT_WR, ST_PT_RD, ST_NZ_LOAD, ST_NZ_R1, ST_NZ_C1, ST_NZ_R2,
		ST_NZ_C2, ST_HALT
	} cmpt_state_t;

	// Fixed pattern for a list index.
	function automatic logic [DATA_W-1:0] pattern_of(input logic [2:0] idx);
		case (idx)
			3'h0:    pattern_of = 16'h0000;
			3'h1:    pattern_of = 16'hFFFF;
			3'h2:    pattern_of = 16'h5555;
			3'h3:    pattern_of = 16'hAAAA;
			3'h4:    pattern_of = 16'h3333;
			default: pattern_of = 16'hCCCC;
		endcase
	endfunction : pattern_of

	// Noise load value: part zero puts ones where the two bits differ.
	function automatic logic [DATA_W-1:0] noise_value(input logic [ADDR_W-1:0] a,
		input logic part);
		noise_value = ((a[NOISE_BIT_A] ^ a[NOISE_BIT_B]) ^ part) ? ALL_ONES : ALL_ZEROS;
	endfunction : noise_value

	// Lower bound of the address test: never below the trap area.
	function automatic logic [ADDR_W-1:0] floor_lo(input logic [ADDR_W-1:0] lo);
		floor_lo = (lo < TRAP_LIMIT) ? TRAP_LIMIT : lo;
	endfunction : floor_lo

endpackage : cmpt_pkg

`default_nettype wire

/* File: test/cmpt_core_memory_pattern_tester_test.sv */
// Self-checking bench for the memory pattern tester.
`timescale 1ns/10ps
`default_nettype none
module cmpt_core_memory_pattern_tester_test;
	typedef struct {logic [1:0] sel; logic [15:0] lo, hi, bad, cnt;} cmpt_row_t;
	// Test, zone, faulty address, errors expected per pass.
	cmpt_row_t rows [4] = '{'{2'h0, 16'h0000, 16'h0043, 16'h0000, 16'h0000},
		'{2'h1, 16'h0200, 16'h0203, 16'h0201, 16'h000A},
		'{2'h2, 16'h0300, 16'h0303, 16'h0301, 16'h0006},
		'{2'h3, 16'h01F0, 16'h020F, 16'h01F8, 16'h0002}};
	logic sys_clk_i, rst_n_i, clk_en_i, run_i, busy_o, halted_o, phase_o, pass_done_o;
	logic err_o, err_ones_o, err_zeros_o, mem_req_o, mem_we_o, mem_done_i, seen_o, seen_z;
	logic seen_p;
	logic [1:0]  test_sel_i, test_o;
	logic [15:0] zone_lo_i, zone_hi_i, bad_a, err_addr_o, err_exp_o, err_got_o, err_count_o;
	logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
	int          fails, checks_done;
	cmpt_core_memory_pattern_tester DUT (.sys_clk_i, .rst_n_i, .clk_en_i, .run_i, .test_sel_i,
		.zone_lo_i, .zone_hi_i, .busy_o, .halted_o, .phase_o, .test_o, .pass_done_o, .err_o,
		.err_ones_o, .err_zeros_o, .err_addr_o, .err_exp_o, .err_got_o, .err_count_o,
		.mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_done_i);
	cmpt_mem_model u_mem (.sys_clk_i, .rst_n_i, .mem_req_o, .mem_we_o, .mem_addr_o,
		.mem_wdata_o, .bad_a, .mem_done_i, .mem_rdata_i);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	// Bounded wait for a flag; running out is a mismatch.
	task automatic wait_for(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 20000)
		begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		if (n >= 20000)
		begin
			fails++;
			finish_test();
		end
	endtask : wait_for
	// Stop, load a new test and restart it.
	task automatic start(input cmpt_row_t r);
		@(posedge sys_clk_i);
		run_i <= 1'b0;
		test_sel_i <= r.sel;
		zone_lo_i <= r.lo;
		zone_hi_i <= r.hi;
		bad_a <= r.bad;
		repeat (3) @(posedge sys_clk_i);
		run_i <= 1'b1;
	endtask : start
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// Remember that both kinds of disturbance and the second phase were seen.
	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i) {seen_o, seen_z, seen_p} <= '0;
		else
		begin
			if (err_ones_o === 1'b1) seen_o <= 1'b1;
			if (err_zeros_o === 1'b1) seen_z <= 1'b1;
			if (phase_o === 1'b1) seen_p <= 1'b1;
		end
	end
	initial
	begin
		{rst_n_i, run_i, test_sel_i} = '0;
		{zone_lo_i, zone_hi_i, bad_a} = '0;
		clk_en_i = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1 chk(err_count_o, 16'h0000);
		foreach (rows[i])
		begin
			start(rows[i]);
			wait_for(pass_done_o);
			chk(err_count_o, rows[i].cnt);
			chk(halted_o, 16'h0000);
			chk(busy_o, 16'h0001);
			chk(test_o, rows[i].sel);
		end
		chk(seen_o & seen_z, 16'h0001);
		chk(seen_p, 16'h0001);
		start('{2'h0, 16'h0040, 16'h0047, 16'h0045, 16'h0000});
		wait_for(halted_o);
		repeat (20) @(posedge sys_clk_i);
		chk(err_addr_o, 16'h0045);
		chk(err_got_o, 16'hFFBA);
		chk(err_count_o, 16'h0001);
		// A low clock enable must freeze the halt even though run has dropped.
		clk_en_i <= 1'b0;
		run_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1 chk(halted_o, 16'h0001);
		@(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1 chk(halted_o, 16'h0000);
		finish_test();
	end
endmodule : cmpt_core_memory_pattern_tester_test
`default_nettype wire

/* File: test/cmpt_mem_model.sv */
// Behavioural core memory that answers the tester's access port.
`timescale 1ns/10ps
`default_nettype none
module cmpt_mem_model (
	input  wire logic        sys_clk_i, rst_n_i, mem_req_o, mem_we_o,
	input  wire logic [15:0] mem_addr_o, mem_wdata_o, bad_a,
	output var  logic        mem_done_i,
	output var  logic [15:0] mem_rdata_i
);
	logic [15:0] mem_r [0:65535]; // One word per address.
	logic [1:0]  wait_r;          // Wait cycles spent on this access.
	// Odd addresses answer one cycle later than even ones; a read of bad_a returns
	// the complement, so a faulty location can be planted per scenario.
	// Between accesses read data toggles so stale data never looks valid.
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			wait_r <= 2'h0;
			mem_done_i <= 1'b0;
			mem_rdata_i <= 16'h0000;
		end
		else if (mem_req_o && !mem_done_i && wait_r == {1'b0, mem_addr_o[0]})
		begin
			wait_r <= 2'h0;
			mem_done_i <= 1'b1;
			if (mem_we_o) mem_r[mem_addr_o] <= mem_wdata_o;
			mem_rdata_i <= (mem_addr_o == bad_a) ? ~mem_r[mem_addr_o] : mem_r[mem_addr_o];
		end
		else
		begin
			wait_r <= (mem_req_o && !mem_done_i) ? wait_r + 2'h1 : wait_r;
			mem_done_i <= 1'b0;
			mem_rdata_i <= ~mem_rdata_i;
		end
endmodule : cmpt_mem_model
`default_nettype wire

/* File: test/cmpt_props.sv */
// Port checker for the memory pattern tester.
`timescale 1ns/10ps
`default_nettype none
module cmpt_props (
	input wire logic        sys_clk_i, rst_n_i, clk_en_i, run_i, busy_o, halted_o,
	input wire logic        err_o, err_ones_o, err_zeros_o, mem_req_o, mem_we_o, mem_done_i,
	input wire logic [1:0]  test_o,
	input wire logic [15:0] err_exp_o, mem_addr_o, mem_wdata_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_req_hold: assert property (mem_req_o && !mem_done_i && clk_en_i && run_i |=>
		mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("request moved");
	a_req_gap: assert property (mem_req_o && mem_done_i && clk_en_i |=>
		!mem_req_o ##1 !mem_req_o) else $error("request gap too short");
	a_start_issue: assert property ($rose(busy_o) |=> $rose(mem_req_o))
		else $error("first access late");
	a_addr_data: assert property (mem_req_o && mem_we_o && test_o == 2'h0 |->
		mem_wdata_o == mem_addr_o) else $error("address test data wrong");
	a_trap_floor: assert property (mem_req_o && busy_o && test_o == 2'h0 |->
		mem_addr_o >= 16'h0040) else $error("trap area touched");
	a_err_halt: assert property (err_o && test_o == 2'h0 |-> ##[0:1] halted_o)
		else $error("no halt after mismatch");
	a_halt_hold: assert property (halted_o && run_i |=> halted_o && !mem_req_o)
		else $error("halt left");
	a_err_ones: assert property (err_ones_o |-> err_o && err_exp_o == 16'hFFFF)
		else $error("ones report wrong");
	a_err_zeros: assert property (err_zeros_o |-> err_o && err_exp_o == 16'h0000)
		else $error("zeros report wrong");
endmodule : cmpt_props
bind cmpt_core_memory_pattern_tester cmpt_props u_props (.sys_clk_i, .rst_n_i, .clk_en_i,
	.run_i, .busy_o, .halted_o, .err_o, .err_ones_o, .err_zeros_o, .mem_req_o, .mem_we_o,
	.mem_done_i, .test_o, .err_exp_o, .mem_addr_o, .mem_wdata_o);
`default_nettype wire
